/* File: design/usi_irq.sv */
`default_nettype none
module usi_irq
	import usi_pkg::*;
#(
	parameter int CHANNEL = 0
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	input  wire logic        multidrop_mode,
	input  wire logic        special_char_detect,
	input  wire logic        addr_char_rx,
	input  wire logic        line_break_rx,
	input  wire logic        stop_char_b_rx,
	input  wire logic        stop_char_a_rx,
	input  wire logic        resume_char_b_rx,
	input  wire logic        resume_char_a_rx,
	input  wire logic        clock_settled_in,
	input  wire logic        crystal_source,
	input  wire logic        clock_disabled,
	input  wire logic [15:0] gpio_in,
	input  wire logic        main_irq_register_rd,
	output logic             special_char_summary,
	output logic             status_summary
);
	// only four channels exist, each owning one group of four lines
	if (CHANNEL < 0 || CHANNEL >= NUM_CHAN) begin : g_bad_channel
		$error("channel out of range");
	end

	logic [7:0] special_char_irq_enable;
	logic [7:0] special_char_irq_flags;
	logic [7:0] status_irq_enable;
	logic       clock_settled;
	logic [3:0] pin_change_flag;
	logic [3:0] pin_prev;
	logic       pin_valid;
	logic [7:0] next_spc_en, next_spc_flg, next_sts_en;
	logic       next_clock_settled;
	logic [3:0] next_pin_flag;
	logic       next_spc_sum, next_sts_sum;
	logic [7:0] next_rdata;
	logic [7:0] spc_set;
	logic [3:0] pins;
	logic [3:0] pin_edge;
	logic       rd_spc, rd_sts, spc_hit, sts_hit;

	always_comb begin
		pins = gpio_in[CHANNEL*GPIO_PER_CHAN +: GPIO_PER_CHAN];
		rd_spc = reg_rd && reg_addr == SPC_FLG_ADDR;
		rd_sts = reg_rd && reg_addr == STS_FLG_ADDR;
		spc_set = 8'h00;
		spc_set[BIT_ADDR_CHAR] = addr_char_rx && multidrop_mode;
		spc_set[BIT_BREAK] = line_break_rx;
		spc_set[BIT_STOP_B] = stop_char_b_rx && special_char_detect;
		spc_set[BIT_STOP_A] = stop_char_a_rx && special_char_detect;
		spc_set[BIT_RESUME_B] = resume_char_b_rx && special_char_detect;
		spc_set[BIT_RESUME_A] = resume_char_a_rx && special_char_detect;
		next_spc_en = special_char_irq_enable;
		next_sts_en = status_irq_enable;
		if (reg_wr && reg_addr == SPC_EN_ADDR)
			next_spc_en = reg_wdata & SPC_MASK;
		if (reg_wr && reg_addr == STS_EN_ADDR)
			next_sts_en = reg_wdata & STS_MASK;
		// set after clear so a coincident event survives the read
		next_spc_flg = (rd_spc ? 8'h00 : special_char_irq_flags) | spc_set;
		// the first sample after reset only primes the history, so no false edge
		pin_edge = pin_valid ? (pins ^ pin_prev) : 4'h0;
		next_pin_flag = (rd_sts ? 4'h0 : pin_change_flag) | pin_edge;
		// read never touches clock-ready; disable or a non-crystal source drops it
		if (clock_disabled || !crystal_source)
			next_clock_settled = 1'b0;
		else
			next_clock_settled = clock_settled | clock_settled_in;
		// next enables too, so a flag read right after the enable write still raises
		spc_hit = |(next_spc_flg & next_spc_en);
		sts_hit = (next_clock_settled && next_sts_en[BIT_CLK_READY])
			|| |(next_pin_flag & next_sts_en[3:0]);
		next_spc_sum = (main_irq_register_rd ? 1'b0 : special_char_summary) | spc_hit;
		next_sts_sum = (main_irq_register_rd ? 1'b0 : status_summary) | sts_hit;
		case (reg_addr)
			SPC_EN_ADDR:  next_rdata = special_char_irq_enable;
			SPC_FLG_ADDR: next_rdata = special_char_irq_flags;
			STS_EN_ADDR:  next_rdata = status_irq_enable;
			STS_FLG_ADDR: next_rdata = {2'b00, clock_settled, 1'b0, pin_change_flag};
			default:      next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			special_char_irq_enable <= REG_RESET;
			special_char_irq_flags  <= REG_RESET;
			status_irq_enable       <= REG_RESET;
			clock_settled           <= 1'b0;
			pin_change_flag         <= 4'h0;
			pin_prev                <= 4'h0;
			pin_valid               <= 1'b0;
			special_char_summary    <= 1'b0;
			status_summary          <= 1'b0;
			reg_rdata               <= 8'h00;
		end else begin
			special_char_irq_enable <= next_spc_en;
			special_char_irq_flags  <= next_spc_flg;
			status_irq_enable       <= next_sts_en;
			clock_settled           <= next_clock_settled;
			pin_change_flag         <= next_pin_flag;
			pin_prev                <= pins;
			pin_valid               <= 1'b1;
			special_char_summary    <= next_spc_sum;
			status_summary          <= next_sts_sum;
			reg_rdata               <= next_rdata;
		end
	end

	// a flag read with no event landing in the same cycle
	sequence s_spc_quiet_read;
		rd_spc && spc_set == 8'h00;
	endsequence

	sequence s_sts_quiet_read;
		rd_sts && pin_edge == 4'h0;
	endsequence

	// an enabled flag standing in its register
	sequence s_spc_enabled_flag;
		|(special_char_irq_flags & special_char_irq_enable);
	endsequence

	a_spc_read_clear: assert property (@(posedge clk) disable iff (reset)
		s_spc_quiet_read |=> special_char_irq_flags == 8'h00)
		else $error("special flags not cleared by read");

	a_spc_set_wins: assert property (@(posedge clk) disable iff (reset)
		rd_spc && spc_set[BIT_BREAK] |=> special_char_irq_flags[BIT_BREAK])
		else $error("break flag lost on read");

	a_addr_char_set: assert property (@(posedge clk) disable iff (reset)
		addr_char_rx && multidrop_mode |=> special_char_irq_flags[BIT_ADDR_CHAR])
		else $error("address flag not set");

	a_break_set: assert property (@(posedge clk) disable iff (reset)
		line_break_rx |=> special_char_irq_flags[BIT_BREAK])
		else $error("break flag not set");

	a_resume_set: assert property (@(posedge clk) disable iff (reset)
		resume_char_a_rx && special_char_detect |=> special_char_irq_flags[BIT_RESUME_A])
		else $error("resume flag not set");

	a_special_gate: assert property (@(posedge clk) disable iff (reset)
		!special_char_detect && !rd_spc && !special_char_irq_flags[BIT_STOP_A]
		|=> !special_char_irq_flags[BIT_STOP_A])
		else $error("stop flag set while detection off");

	a_spc_summary: assert property (@(posedge clk) disable iff (reset)
		s_spc_enabled_flag |-> special_char_summary)
		else $error("special summary missing");

	a_spc_blocked: assert property (@(posedge clk) disable iff (reset)
		special_char_irq_enable == 8'h00 && !(reg_wr && reg_addr == SPC_EN_ADDR)
		&& !special_char_summary |=> !special_char_summary)
		else $error("special summary raised while masked");

	a_spc_main_clear: assert property (@(posedge clk) disable iff (reset)
		main_irq_register_rd && special_char_irq_flags == 8'h00 && spc_set == 8'h00
		|=> !special_char_summary)
		else $error("special summary not cleared");

	a_clk_rdy_set: assert property (@(posedge clk) disable iff (reset)
		clock_settled_in && crystal_source && !clock_disabled |=> clock_settled)
		else $error("clock ready not set");

	a_clk_rdy_xtal: assert property (@(posedge clk) disable iff (reset)
		!crystal_source |=> !clock_settled)
		else $error("clock ready without crystal");

	a_clk_rdy_hold: assert property (@(posedge clk) disable iff (reset)
		clock_settled && !clock_disabled && crystal_source |=> clock_settled)
		else $error("clock ready dropped");

	a_clk_rdy_drop: assert property (@(posedge clk) disable iff (reset)
		clock_disabled |=> !clock_settled)
		else $error("clock ready kept while disabled");

	a_sts_summary: assert property (@(posedge clk) disable iff (reset)
		clock_settled && status_irq_enable[BIT_CLK_READY] |-> status_summary)
		else $error("status summary missing");

	a_gpio_summary: assert property (@(posedge clk) disable iff (reset)
		|(pin_change_flag & status_irq_enable[3:0]) |-> status_summary)
		else $error("pin summary missing");

	a_sts_main_clear: assert property (@(posedge clk) disable iff (reset)
		main_irq_register_rd && clock_disabled
		&& pin_change_flag == 4'h0 && pin_edge == 4'h0 |=> !status_summary)
		else $error("status summary not cleared");

	a_reserved_zero: assert property (@(posedge clk) disable iff (reset)
		special_char_irq_enable[7:6] == 2'b00 && special_char_irq_flags[7:6] == 2'b00
		&& status_irq_enable[7:6] == 2'b00 && status_irq_enable[4] == 1'b0)
		else $error("reserved bits set");

	a_pin_change: assert property (@(posedge clk) disable iff (reset)
		pin_edge != 4'h0 |=> (pin_change_flag & $past(pin_edge)) == $past(pin_edge))
		else $error("pin change missed");

	a_sts_read_clear: assert property (@(posedge clk) disable iff (reset)
		s_sts_quiet_read |=> pin_change_flag == 4'h0)
		else $error("pin flags not cleared by read");
endmodule // usi_irq
`default_nettype wire

/* File: design/usi_pkg.sv */
`default_nettype none
package usi_pkg;
	localparam logic [7:0] SPC_EN_ADDR  = 8'h05;
	localparam logic [7:0] SPC_FLG_ADDR = 8'h06;
	localparam logic [7:0] STS_EN_ADDR  = 8'h07;
	localparam logic [7:0] STS_FLG_ADDR = 8'h08;
	localparam logic [7:0] REG_RESET    = 8'h00;
	localparam int BIT_ADDR_CHAR  = 5;
	localparam int BIT_BREAK      = 4;
	localparam int BIT_STOP_B     = 3;
	localparam int BIT_STOP_A     = 2;
	localparam int BIT_RESUME_B   = 1;
	localparam int BIT_RESUME_A   = 0;
	localparam int BIT_CLK_READY  = 5;
	localparam int GPIO_PER_CHAN  = 4;
	localparam int NUM_GPIO       = 16;
	localparam int NUM_CHAN       = 4;
	localparam logic [7:0] SPC_MASK = 8'h3F;
	localparam logic [7:0] STS_MASK = 8'h2F;
endpackage
`default_nettype wire

/* File: verification/usi_host.sv */
`default_nettype none
module usi_host (
	input  wire logic       clk,
	output logic      [7:0] reg_addr,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	input  wire logic [7:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// one strobe cycle, then an idle cycle, so strobes never merge
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge clk);
		reg_addr = a;
		reg_wr = w;
		reg_rd = !w;
		reg_wdata = d;
		@(negedge clk);
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	endtask
endmodule // usi_host
`default_nettype wire

/* File: verification/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import usi_pkg::*;
	logic        clk = 1'b0, reset = 1'b1, md = 1'b0, det = 1'b0;
	logic        xtal = 1'b0, cset = 1'b0, cdis = 1'b0;
	logic [6:0]  ev = 7'h00;
	logic [15:0] gpio = 16'h0000;
	logic [7:0]  addr, wdata, rdata, q;
	logic        wr, rd, spc_sum, sts_sum;
	int          error_cnt = 0, check_count = 0;
	initial forever #20 clk = ~clk;
	usi_host usi_host_i (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wdata), .reg_rdata(rdata));
	usi_irq #(.CHANNEL(2)) usi_irq_i (.clk(clk), .reset(reset), .reg_addr(addr),
		.reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
		.multidrop_mode(md), .special_char_detect(det), .addr_char_rx(ev[5]),
		.line_break_rx(ev[4]), .stop_char_b_rx(ev[3]), .stop_char_a_rx(ev[2]),
		.resume_char_b_rx(ev[1]), .resume_char_a_rx(ev[0]), .clock_settled_in(cset),
		.crystal_source(xtal), .clock_disabled(cdis), .gpio_in(gpio),
		.main_irq_register_rd(ev[6]), .special_char_summary(spc_sum),
		.status_summary(sts_sum));
	task automatic chk(input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, e);
		usi_host_i.acc(1'b0, a, 8'h00, q);
		chk(e, q);
	endtask
	// bit 6 is the main register read, bits 5..0 line up with the flag bits
	task automatic pulse(input logic [6:0] m);
		@(negedge clk);
		ev = m;
		@(negedge clk);
		ev = 7'h00;
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		give_verdict();
	end
	initial begin
		repeat (2) @(negedge clk);
		reset = 1'b0;
		rd_chk(SPC_EN_ADDR, REG_RESET);
		rd_chk(SPC_FLG_ADDR, REG_RESET);
		rd_chk(STS_EN_ADDR, REG_RESET);
		rd_chk(8'h0B, 8'h00);
		usi_host_i.acc(1'b1, SPC_FLG_ADDR, 8'hFF, q);
		pulse(7'h3F);
		rd_chk(SPC_FLG_ADDR, 8'h10);
		md = 1'b1;
		det = 1'b1;
		pulse(7'h3F);
		chk(8'h00, {7'h00, spc_sum});
		usi_host_i.acc(1'b1, SPC_EN_ADDR, 8'hFF, q);
		rd_chk(SPC_EN_ADDR, SPC_MASK);
		chk(8'h01, {7'h00, spc_sum});
		rd_chk(SPC_FLG_ADDR, SPC_MASK);
		rd_chk(SPC_FLG_ADDR, 8'h00);
		pulse(7'h40);
		chk(8'h00, {7'h00, spc_sum});
		// break and resume land in the very cycle of the clearing read
		fork
			rd_chk(SPC_FLG_ADDR, 8'h00);
			pulse(7'h11);
		join
		rd_chk(SPC_FLG_ADDR, 8'h11);
		chk(8'h01, {7'h00, spc_sum});
		xtal = 1'b1;
		cset = 1'b1;
		rd_chk(STS_FLG_ADDR, 8'h20);
		gpio = 16'h0201;
		rd_chk(STS_FLG_ADDR, 8'h22);
		rd_chk(STS_FLG_ADDR, 8'h20);
		chk(8'h00, {7'h00, sts_sum});
		usi_host_i.acc(1'b1, STS_EN_ADDR, 8'hFF, q);
		rd_chk(STS_EN_ADDR, STS_MASK);
		chk(8'h01, {7'h00, sts_sum});
		cdis = 1'b1;
		rd_chk(STS_FLG_ADDR, 8'h00);
		usi_host_i.acc(1'b1, STS_EN_ADDR, 8'h0F, q);
		pulse(7'h40);
		chk(8'h00, {7'h00, sts_sum});
		gpio = 16'h0A01;
		rd_chk(STS_FLG_ADDR, 8'h08);
		chk(8'h01, {7'h00, sts_sum});
		cdis = 1'b0;
		xtal = 1'b0;
		rd_chk(STS_FLG_ADDR, 8'h00);
		give_verdict();
	end
endmodule // tb_top
`default_nettype wire
